// file: bench/fdx_drive_model.sv
// Drive model: index once a turn, byte slots, track written and replayed.
module fdx_drive_model #(
  parameter int DIV = 4,
  parameter int TRK = 600
) (
  input wire logic CLK,
  input wire logic RST,
  output logic INDEX_PULSE = 1'b0,
  output logic BYTE_TICK = 1'b0,
  output logic RD_VALID = 1'b0,
  output logic [7:0] RD_DATA = 8'h00,
  output logic RD_MARK = 1'b0,
  input wire logic WR_GATE,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_MARK
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  // The track starts as gap bytes, so a search before any format finds
  // no mark. Each slot keeps the mark flag beside its byte.
  logic [8:0] trk [TRK] = '{default: 9'h04E};
  always @(posedge CLK) begin
    cnt <= (RST || cnt == DIV * TRK - 1) ? 0 : cnt + 1;
    INDEX_PULSE <= !RST && cnt == 0;
    BYTE_TICK <= !RST && cnt % DIV == 0;
    RD_VALID <= !RST && BYTE_TICK && !WR_GATE;
    {RD_MARK, RD_DATA} <= trk[cnt / DIV];
    if (BYTE_TICK && WR_GATE)
      trk[cnt / DIV] <= {WR_MARK, WR_DATA};
  end
endmodule : fdx_drive_model

// file: bench/fdx_engine_properties.sv
// Port checker for the disk command engine, bound to its top module.
module fdx_engine_properties (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [31:0] PRDATA,
  input wire logic BYTE_TICK,
  input wire logic WR_GATE,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_MARK
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  sequence acc_first;
    PSEL && PENABLE && !$past(PENABLE) && !PREADY;
  endsequence
  // The reset edge itself may move the write lines, so it is excluded.
  sequence slot_quiet;
    !$past(BYTE_TICK) && !$past(RST);
  endsequence
  ready_wait_a: assert property (acc_first |=> PREADY)
    else $error("ready late");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready held");
  ready_cause_a: assert property (PREADY |-> PSEL && $past(PENABLE))
    else $error("ready unasked");
  err_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0000_0000)
    else $error("read data off cycle");
  mark_byte_a: assert property (
    WR_MARK |-> WR_DATA == 8'hA1 || WR_DATA == 8'hC2)
    else $error("mark flag on data byte");
  byte_hold_a: assert property (
    slot_quiet |-> $stable(WR_DATA) && $stable(WR_MARK))
    else $error("byte moved off slot");
  gate_hold_a: assert property (slot_quiet |-> $stable(WR_GATE))
    else $error("gate moved off slot");
endmodule : fdx_engine_properties
bind fdx_engine fdx_engine_properties u_fdx_engine_properties (.*);

// file: bench/fdx_engine_tb_top.sv
// Self-checking bench for the disk command engine.
module fdx_engine_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0;
  logic PWRITE = 1'b0, TRANSFER_DONE = 1'b0, cap = 1'b0, e;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [31:0] PRDATA, q;
  logic PREADY, PSLVERR, INDEX_PULSE, BYTE_TICK, RD_VALID, RD_MARK;
  logic WR_GATE, WR_MARK, IRQ;
  logic [7:0] RD_DATA, WR_DATA;
  logic [7:0] wq[$];
  int fail_count = 0, checks = 0, cyc = 0;
  fdx_engine u_fdx_engine (.*);
  fdx_drive_model u_fdx_drive_model (.*);
  initial begin
    forever #25 CLK = ~CLK;
  end
  // A hung wait ends the run here instead of stalling it.
  always @(posedge CLK) begin
    cyc++;
    if (cap && BYTE_TICK && WR_GATE)
      wq.push_back(WR_DATA);
    if (cyc == 60000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s: %h not %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK) PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask : apb
  task automatic wait_hi(input logic irq_sel, input int lim);
    int n;
    n = 0;
    while ((irq_sel ? IRQ : INDEX_PULSE) !== 1'b1 && n < lim) begin
      @(posedge CLK);
      n++;
    end
  endtask : wait_hi
  task automatic t_regs();
    int n;
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk(q, 32'h0000_0000, "mask reset");
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk({q[31:1], e}, 32'h0000_0001, "unmapped");
    apb(1'b1, 8'h0C, 32'h0000_0005);
    apb(1'b1, 8'h08, 32'h0000_0109);
    apb(1'b1, 8'h00, 32'h0000_000D);
    n = 0;
    q = 32'h0000_0000;
    while (q[1:0] === 2'b00 && n++ < 50)
      apb(1'b0, 8'h14, 32'h0000_0000);
    chk(q & 32'h0000_0100, 32'h0000_0100, "invalid");
    chk(32'(IRQ), 32'h0000_0000, "masked irq");
    $display("register test over");
  endtask : t_regs
  task automatic t_verify();
    apb(1'b1, 8'h18, 32'h0000_0001);
    apb(1'b1, 8'h08, 32'h0000_FF01);
    apb(1'b1, 8'h00, 32'h0000_0005);
    TRANSFER_DONE <= 1'b1;
    @(posedge CLK) TRANSFER_DONE <= 1'b0;
    repeat (100) @(posedge CLK);
    chk(32'(IRQ), 32'h0000_0000, "ended by done pin");
    wait_hi(1'b1, 8000);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk(q & 32'h0000_0805, 32'h0000_0801, "not found");
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk(q & 32'h0000_000F, 32'h0000_0000, "read clear");
    $display("verify test over");
  endtask : t_verify
  task automatic t_format(input logic [1:0] lay, input int g1, f, g2,
    input logic [7:0] am);
    int n, r, m;
    wq.delete();
    apb(1'b1, 8'h08, 32'h6D54_0100);
    apb(1'b1, 8'h04, 32'h0000_0100);
    wait_hi(1'b0, 5000);
    @(posedge CLK) cap <= 1'b1;
    apb(1'b1, 8'h00, 32'({lay, 5'h06}));
    wait_hi(1'b0, 5000);
    chk(32'(WR_GATE), 32'h0000_0000, "gate before index");
    @(posedge CLK);
    wait_hi(1'b1, 5000);
    cap <= 1'b0;
    n = 0;
    while (wq[n] === 8'h4E) n++;
    chk(n, g1, "lead gap");
    chk(wq[g1 + 15], am, "first mark");
    chk(wq[f], 8'hFE, "id mark");
    n = 0;
    while (wq[f + 7 + n] === 8'h4E) n++;
    chk(n, g2, "second gap");
    r = 0;
    m = 0;
    foreach (wq[i]) begin
      r = (wq[i] === 8'h6D) ? r + 1 : 0;
      m = (r > m) ? r : m;
    end
    chk(m, 128, "fill");
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk(q & 32'h0000_0001, 32'h0000_0001, "done");
    $display("format test %0d over", lay);
  endtask : t_format
  task automatic t_reread();
    apb(1'b1, 8'h08, 32'h6D54_0101);
    apb(1'b1, 8'h00, 32'h0000_000D);
    wait_hi(1'b1, 6000);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk(q & 32'h0000_0F03, 32'h0000_0001, "verify");
    wq.delete();
    cap <= 1'b1;
    apb(1'b1, 8'h00, 32'h0000_0004);
    wait_hi(1'b1, 6000);
    cap <= 1'b0;
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk(wq[15], 32'h0000_00F8, "deleted mark");
    chk(q & 32'h0000_0403, 32'h0000_0401, "write end");
    $display("reread test over");
  endtask : t_reread
  initial begin
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    t_regs();
    t_verify();
    t_format(2'h0, 80, 161, 22, 8'hFC);
    t_format(2'h1, 32, 47, 22, 8'hFE);
    t_format(2'h2, 80, 161, 41, 8'hFC);
    t_reread();
    final_report();
  end
endmodule : fdx_engine_tb_top

// file: rtl/fdx_consts.svh
// Constants for the disk write, verify and format command engine.
// Operation
// - Write-deleted-data writes sectors like a normal write, with deleted mark.
// - Verify reads each sector, checks its CRC, passes no data to host.
// - Verify never ends on the external transfer-done input.
// - Implicit stop ends verify when sector count reaches zero; zero means 256.
// - Without implicit stop verify ends at final sector; host sets count FF.
// - Implicit stop with count or final sector out of range ends invalid.
// - Two-side mode continues verifying on side 1 after side 0 ends.
// - Format waits for an index pulse before writing anything.
// - Format fills data with fill byte; sizes from size, count, gap3.
// - Format writes count sectors, then gap bytes until the next index pulse, then ends; an earlier index pulse ends it after the current sector.
// - Double-density layout: index preamble, gap1, ID field, gap2 22, data.
// - ISO layout omits index preamble and starts with a 32-byte gap.
// - Perpendicular layout uses a 41-byte gap2.
// - Gap3 length is a programmable parameter, not a constant.
`ifndef FDX_CONSTS_SVH
`define FDX_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------------
`define FDX_OFF_CTRL 8'h00
`define FDX_OFF_ADDR 8'h04
`define FDX_OFF_PARM 8'h08
`define FDX_OFF_GEOM 8'h0C
`define FDX_OFF_DATA 8'h10
`define FDX_OFF_STAT 8'h14
`define FDX_OFF_MASK 8'h18

// ----------------------------------------------------------------------
// Status layout.
// ----------------------------------------------------------------------
`define FDX_EV_W 4
`define FDX_EV_DONE 0
`define FDX_EV_ERR 1
`define FDX_EV_DATA 2
`define FDX_EV_ID 3
`define FDX_FLAG_LSB 8

// ----------------------------------------------------------------------
// Track bytes.
// ----------------------------------------------------------------------
`define FDX_GAP_BYTE 8'h4E
`define FDX_SYNC_BYTE 8'h00
`define FDX_MARK_A1 8'hA1
`define FDX_MARK_C2 8'hC2
`define FDX_AM_INDEX 8'hFC
`define FDX_AM_ID 8'hFE
`define FDX_AM_DATA 8'hFB
`define FDX_AM_DEL 8'hF8

// ----------------------------------------------------------------------
// Field lengths in bytes.
// ----------------------------------------------------------------------
`define FDX_N_NONE 16'h0000
`define FDX_N_ONE 16'h0001
`define FDX_N_GAP4A 16'h0050
`define FDX_N_GAP_ISO 16'h0020
`define FDX_N_SYNC 16'h000C
`define FDX_N_MARK 16'h0003
`define FDX_N_GAP1 16'h0032
`define FDX_N_ID 16'h0004
`define FDX_N_CRC 16'h0002
`define FDX_N_GAP2 16'h0016
`define FDX_N_GAP2_PERP 16'h0029
`define FDX_N_TAIL 16'hFFFF
`define FDX_N_BASE_LEN 16'h0080
`define FDX_ID_LAST 16'h0006

// ----------------------------------------------------------------------
// Segment indices, counts and CRC.
// ----------------------------------------------------------------------
`define FDX_SEG_FIRST 5'h00
`define FDX_SEG_SECTOR 5'h05
`define FDX_SEG_GAP2 5'h0A
`define FDX_SEG_GAP3 5'h10
`define FDX_SEG_TAIL 5'h11
`define FDX_FULL_COUNT 9'h100
`define FDX_COUNT_ONE 9'h001
`define FDX_FIRST_SECTOR 8'h01
`define FDX_IDX_LIMIT 2'h1
`define FDX_CRC_INIT 16'hFFFF
`define FDX_CRC_POLY 16'h1021

`endif

// file: rtl/fdx_crc16.sv
// Byte-wide CCITT CRC register with synchronous preset.
`include "fdx_consts.svh"
module fdx_crc16 (
  input wire logic clk,
  input wire logic rst,
  input wire logic init,
  input wire logic en,
  input wire logic [7:0] data,
  output logic [15:0] crc
);
  logic [15:0] next_crc;
  logic fb;

  // A preset and a feed in one cycle start from the preset value.
  always_comb begin
    next_crc = init ? `FDX_CRC_INIT : crc;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      fb = next_crc[15] ^ data[i];
      next_crc = {next_crc[14:0], 1'b0} ^ (fb ? `FDX_CRC_POLY : 16'h0000);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      crc <= `FDX_CRC_INIT;
    end else if (en) begin
      crc <= next_crc;
    end else if (init) begin
      crc <= `FDX_CRC_INIT;
    end
  end
endmodule : fdx_crc16

// file: rtl/fdx_engine.sv
// Write-deleted, verify and format command engine with an APB slave.
//
// Local design decisions: the APB register port and the address map.
`include "fdx_consts.svh"
module fdx_engine
  import fdx_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic INDEX_PULSE,
  input wire logic TRANSFER_DONE,
  input wire logic BYTE_TICK,
  input wire logic RD_VALID,
  input wire logic [7:0] RD_DATA,
  input wire logic RD_MARK,
  output logic WR_GATE,
  output logic [7:0] WR_DATA,
  output logic WR_MARK,
  output logic IRQ
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_CHECK, ST_WAIT_IDX, ST_SEARCH, ST_READ, ST_EMIT
  } fdx_state_t;
  typedef enum logic [1:0] {P_HUNT, P_TYPE, P_ID, P_DATA} fdx_pstate_t;

  fdx_state_t state;
  fdx_pstate_t pstate;
  fdx_ctrl_t ctrl;
  fdx_id_t addr_reg;
  fdx_id_t cur;
  fdx_id_t rid;
  fdx_seg_t seg;
  logic [7:0] final_sector, sector_total, gap3_len, fill_byte;
  logic [7:0] sps, data_len, host_byte;
  logic host_full;
  logic [`FDX_EV_W-1:0] stat, mask, ev;
  logic ev_done, ev_err;
  logic invalid, crc_err, underrun, no_sector;
  logic [8:0] count, secs_left;
  logic [9:0] remaining;
  logic [4:0] seg_idx;
  logic [15:0] seg_cnt, p_cnt, data_bytes, data_last;
  logic [1:0] idx_cnt;
  logic idx_hit, td_seen, id_fin, data_fin;
  logic [15:0] wcrc, rcrc;
  logic acc, done_w, done_r, go, bad, match;
  logic emit, seg_last, seg_step, consume, adv, adv_end, fail, fin;
  logic [7:0] out_byte;
  logic [31:0] rdata;
  logic hit;

  // ----------------------------------------------------------------------
  // APB slave: one wait state, answer registered.
  // ----------------------------------------------------------------------
  assign acc = PSEL & PENABLE & ~PREADY;
  assign done_w = PSEL & PENABLE & PREADY & PWRITE;
  assign done_r = PSEL & PENABLE & PREADY & ~PWRITE;

  always_comb begin
    hit = 1'b1;
    rdata = '0;
    case (PADDR)
      `FDX_OFF_CTRL: rdata = {25'h000_0000, ctrl};
      `FDX_OFF_ADDR: rdata = addr_reg;
      `FDX_OFF_PARM: rdata = {fill_byte, gap3_len, sector_total, final_sector};
      `FDX_OFF_GEOM: rdata = {16'h0000, data_len, sps};
      `FDX_OFF_DATA: rdata = cur;
      `FDX_OFF_STAT: rdata = {20'h0_0000, no_sector, underrun, crc_err,
                              invalid, 4'h0, stat};
      `FDX_OFF_MASK: rdata = {28'h000_0000, mask};
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      PREADY <= 1'b0;
      PRDATA <= '0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= acc;
      PRDATA <= (acc & ~PWRITE) ? rdata : '0;
      PSLVERR <= acc & ~hit;
    end
  end

  // Configuration registers written by software.
  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl <= '0;
      addr_reg <= '0;
      final_sector <= '0;
      sector_total <= '0;
      gap3_len <= '0;
      fill_byte <= '0;
      sps <= '0;
      data_len <= '0;
      mask <= '0;
    end else if (done_w) begin
      case (PADDR)
        `FDX_OFF_CTRL: ctrl <= fdx_ctrl_t'(PWDATA[6:0]);
        `FDX_OFF_ADDR: addr_reg <= PWDATA;
        `FDX_OFF_PARM: {fill_byte, gap3_len, sector_total, final_sector}
                         <= PWDATA;
        `FDX_OFF_GEOM: {data_len, sps} <= PWDATA[15:0];
        `FDX_OFF_MASK: mask <= PWDATA[`FDX_EV_W-1:0];
        default: ;
      endcase
    end else begin
      ctrl.start <= 1'b0;
    end
  end

  // Host data holding byte; a new write in the consuming cycle is kept.
  always_ff @(posedge CLK) begin
    if (RST) begin
      host_byte <= '0;
      host_full <= 1'b0;
    end else if (done_w && PADDR == `FDX_OFF_DATA) begin
      host_byte <= PWDATA[7:0];
      host_full <= 1'b1;
    end else if (consume) begin
      host_full <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Sticky status and interrupt.
  // ----------------------------------------------------------------------
  // Only bits already returned to software are cleared, so an event that
  // lands between the data capture and the clear is kept.
  assign ev = {id_evt(),
               consume, ev_err, ev_done};

  function automatic logic id_evt();
    id_evt = emit && seg.kind == FDX_K_ID && seg_last;
  endfunction : id_evt

  always_ff @(posedge CLK) begin
    if (RST) begin
      stat <= '0;
      IRQ <= 1'b0;
    end else begin
      stat <= (stat & ~((done_r && PADDR == `FDX_OFF_STAT) ?
                         PRDATA[`FDX_EV_W-1:0] : '0)) | ev;
      IRQ <= |(stat & mask);
    end
  end

  // ----------------------------------------------------------------------
  // Read stream parser.
  // ----------------------------------------------------------------------
  assign data_bytes = `FDX_N_BASE_LEN << cur.n[2:0];
  assign data_last = data_bytes + `FDX_N_CRC;

  fdx_crc16 u_rcrc (
    .clk(CLK),
    .rst(RST),
    .init(pstate == P_HUNT),
    .en(RD_VALID),
    .data(RD_DATA),
    .crc(rcrc)
  );

  always_ff @(posedge CLK) begin
    if (RST) begin
      pstate <= P_HUNT;
      p_cnt <= '0;
      rid <= '0;
      id_fin <= 1'b0;
      data_fin <= 1'b0;
    end else begin
      id_fin <= 1'b0;
      data_fin <= 1'b0;
      if (RD_VALID) begin
        p_cnt <= p_cnt + `FDX_N_ONE;
        if (RD_MARK) begin
          pstate <= P_TYPE;
          p_cnt <= '0;
        end else begin
          unique case (pstate)
            P_HUNT: ;
            P_TYPE: begin
              if (RD_DATA == `FDX_AM_ID) begin
                pstate <= P_ID;
              end else if (RD_DATA == `FDX_AM_DATA ||
                           RD_DATA == `FDX_AM_DEL) begin
                pstate <= P_DATA;
              end else begin
                pstate <= P_HUNT;
              end
            end
            P_ID: begin
              if (p_cnt <= `FDX_N_ID) begin
                rid <= {rid[23:0], RD_DATA};
              end
              if (p_cnt == `FDX_ID_LAST) begin
                pstate <= P_HUNT;
                id_fin <= 1'b1;
              end
            end
            P_DATA: begin
              // Data bytes only feed the CRC; nothing reaches the host.
              if (p_cnt == data_last) begin
                pstate <= P_HUNT;
                data_fin <= 1'b1;
              end
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Write stream generator.
  // ----------------------------------------------------------------------
  fdx_layout u_layout (
    .idx(seg_idx),
    .layout(ctrl.layout),
    .deleted(ctrl.cmd == FDX_CMD_WRDEL),
    .gap3_len(gap3_len),
    .data_bytes(data_bytes),
    .seg(seg)
  );

  fdx_crc16 u_wcrc (
    .clk(CLK),
    .rst(RST),
    .init(seg.kind == FDX_K_FILL),
    .en(emit && seg.kind inside {FDX_K_MARK, FDX_K_BYTE, FDX_K_ID,
                                 FDX_K_DATA}),
    .data(out_byte),
    .crc(wcrc)
  );

  always_comb begin
    emit = (state == ST_EMIT) && BYTE_TICK && (seg.count != `FDX_N_NONE);
    seg_last = (seg_cnt == seg.count - `FDX_N_ONE);
    seg_step = (state == ST_EMIT) && (seg.kind != FDX_K_TAIL) &&
               ((seg.count == `FDX_N_NONE) || (emit && seg_last));
    consume = emit && seg.kind == FDX_K_DATA &&
              ctrl.cmd == FDX_CMD_WRDEL && !td_seen;
    unique case (seg.kind)
      FDX_K_ID: out_byte = addr_reg[8*(3-seg_cnt[1:0]) +: 8];
      FDX_K_DATA: begin
        if (ctrl.cmd == FDX_CMD_FORMAT) begin
          out_byte = fill_byte;
        end else begin
          // Underrun or transfer end pads the field with zeros.
          out_byte = (host_full && !td_seen) ? host_byte : 8'h00;
        end
      end
      FDX_K_CRC: out_byte = seg_cnt[0] ? wcrc[7:0] : wcrc[15:8];
      default: out_byte = seg.value;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      WR_GATE <= 1'b0;
      WR_DATA <= '0;
      WR_MARK <= 1'b0;
    end else if (emit) begin
      WR_DATA <= out_byte;
      WR_MARK <= (seg.kind == FDX_K_MARK);
      // A write lets gap2 pass under the head before it turns on.
      WR_GATE <= !(ctrl.cmd == FDX_CMD_WRDEL && seg_idx == `FDX_SEG_GAP2);
    end else if (BYTE_TICK) begin
      WR_GATE <= 1'b0;
      WR_MARK <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Command sequencing.
  // ----------------------------------------------------------------------
  always_comb begin
    go = ctrl.start && state == ST_IDLE && ctrl.cmd != FDX_CMD_NONE;
    match = (rid == cur);
    remaining = 10'({2'b00, sps} - {2'b00, cur.r} + 10'h001 +
                ((ctrl.two_side && !cur.h[0]) ? {2'b00, sps} : 10'h000));
    bad = (final_sector > sps) ||
          (ctrl.implicit_stop && {1'b0, count} > remaining);
    adv = (state == ST_READ && data_fin && rcrc == `FDX_N_NONE) ||
          (seg_step && seg_idx == `FDX_SEG_GAP3 &&
           ctrl.cmd == FDX_CMD_WRDEL);
    adv_end = (ctrl.cmd == FDX_CMD_VERIFY && ctrl.implicit_stop &&
               count == `FDX_COUNT_ONE) ||
              (ctrl.cmd == FDX_CMD_WRDEL && td_seen) ||
              (cur.r == final_sector &&
               !(ctrl.two_side && !cur.h[0]));
    fail = (state == ST_CHECK && bad) ||
           (state == ST_SEARCH && INDEX_PULSE && idx_cnt == `FDX_IDX_LIMIT) ||
           (state == ST_READ && data_fin && rcrc != `FDX_N_NONE);
    fin = fail || (adv && adv_end) ||
          (state == ST_EMIT && seg.kind == FDX_K_TAIL &&
           (INDEX_PULSE || idx_hit));
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= ST_IDLE;
      cur <= '0;
      count <= '0;
      secs_left <= '0;
      seg_idx <= `FDX_SEG_FIRST;
      seg_cnt <= '0;
      idx_cnt <= '0;
      idx_hit <= 1'b0;
      td_seen <= 1'b0;
      ev_done <= 1'b0;
      ev_err <= 1'b0;
      invalid <= 1'b0;
      crc_err <= 1'b0;
      underrun <= 1'b0;
      no_sector <= 1'b0;
    end else begin
      ev_done <= fin;
      ev_err <= fail;
      if (emit) begin
        seg_cnt <= seg_cnt + `FDX_N_ONE;
      end
      if (consume && !host_full) begin
        underrun <= 1'b1;
      end
      // Verify has no host transfer, so only a write watches this input.
      if (ctrl.cmd == FDX_CMD_WRDEL && TRANSFER_DONE && state != ST_IDLE) begin
        td_seen <= 1'b1;
      end
      if (state == ST_EMIT && INDEX_PULSE) begin
        idx_hit <= 1'b1;
      end
      if (seg_step) begin
        seg_cnt <= '0;
        seg_idx <= seg_idx + 5'h01;
        if (seg_idx == `FDX_SEG_GAP3 && ctrl.cmd == FDX_CMD_FORMAT) begin
          secs_left <= secs_left - `FDX_COUNT_ONE;
          seg_idx <= (secs_left == `FDX_COUNT_ONE || idx_hit) ?
                     `FDX_SEG_TAIL : `FDX_SEG_SECTOR;
        end
      end
      unique case (state)
        ST_IDLE: begin
          if (go) begin
            cur <= addr_reg;
            count <= (sector_total == 8'h00) ? `FDX_FULL_COUNT :
                     {1'b0, sector_total};
            idx_cnt <= '0;
            idx_hit <= 1'b0;
            td_seen <= 1'b0;
            invalid <= 1'b0;
            crc_err <= 1'b0;
            underrun <= 1'b0;
            no_sector <= 1'b0;
            unique case (ctrl.cmd)
              FDX_CMD_VERIFY: state <= ST_CHECK;
              FDX_CMD_FORMAT: state <= ST_WAIT_IDX;
              default: state <= ST_SEARCH;
            endcase
          end
        end
        ST_CHECK: begin
          if (bad) begin
            invalid <= 1'b1;
          end
          state <= bad ? ST_IDLE : ST_SEARCH;
        end
        ST_WAIT_IDX: begin
          if (INDEX_PULSE) begin
            state <= ST_EMIT;
            seg_idx <= `FDX_SEG_FIRST;
            seg_cnt <= '0;
            secs_left <= count;
          end
        end
        ST_SEARCH: begin
          if (INDEX_PULSE) begin
            idx_cnt <= idx_cnt + 2'h1;
            no_sector <= (idx_cnt == `FDX_IDX_LIMIT);
          end
          if (id_fin && rcrc == `FDX_N_NONE && match) begin
            idx_cnt <= '0;
            if (ctrl.cmd == FDX_CMD_VERIFY) begin
              state <= ST_READ;
            end else begin
              state <= ST_EMIT;
              seg_idx <= `FDX_SEG_GAP2;
              seg_cnt <= '0;
            end
          end
        end
        ST_READ: begin
          if (data_fin && rcrc != `FDX_N_NONE) begin
            crc_err <= 1'b1;
          end
        end
        ST_EMIT: ;
        default: ;
      endcase
      if (adv && !adv_end) begin
        state <= ST_SEARCH;
        count <= count - `FDX_COUNT_ONE;
        if (cur.r == final_sector) begin
          cur.h[0] <= 1'b1;
          cur.r <= `FDX_FIRST_SECTOR;
        end else begin
          cur.r <= cur.r + 8'h01;
        end
      end
      if (fin) begin
        state <= ST_IDLE;
      end
    end
  end
endmodule : fdx_engine

// file: rtl/fdx_layout.sv
// Track layout table: one segment of bytes per index.
`include "fdx_consts.svh"
module fdx_layout
  import fdx_pkg::*;
(
  input wire logic [4:0] idx,
  input wire fdx_layout_t layout,
  input wire logic deleted,
  input wire logic [7:0] gap3_len,
  input wire logic [15:0] data_bytes,
  output fdx_seg_t seg
);
  logic iso;
  logic perp;

  always_comb begin
    iso = (layout == FDX_LAY_ISO);
    perp = (layout == FDX_LAY_PERP);
    case (idx)
      5'h00: seg = '{FDX_K_FILL, `FDX_GAP_BYTE,
                     iso ? `FDX_N_GAP_ISO : `FDX_N_GAP4A};
      5'h01: seg = '{FDX_K_FILL, `FDX_SYNC_BYTE,
                     iso ? `FDX_N_NONE : `FDX_N_SYNC};
      5'h02: seg = '{FDX_K_MARK, `FDX_MARK_C2,
                     iso ? `FDX_N_NONE : `FDX_N_MARK};
      5'h03: seg = '{FDX_K_BYTE, `FDX_AM_INDEX,
                     iso ? `FDX_N_NONE : `FDX_N_ONE};
      5'h04: seg = '{FDX_K_FILL, `FDX_GAP_BYTE,
                     iso ? `FDX_N_NONE : `FDX_N_GAP1};
      5'h05: seg = '{FDX_K_FILL, `FDX_SYNC_BYTE, `FDX_N_SYNC};
      5'h06: seg = '{FDX_K_MARK, `FDX_MARK_A1, `FDX_N_MARK};
      5'h07: seg = '{FDX_K_BYTE, `FDX_AM_ID, `FDX_N_ONE};
      5'h08: seg = '{FDX_K_ID, `FDX_SYNC_BYTE, `FDX_N_ID};
      5'h09: seg = '{FDX_K_CRC, `FDX_SYNC_BYTE, `FDX_N_CRC};
      5'h0A: seg = '{FDX_K_FILL, `FDX_GAP_BYTE,
                     perp ? `FDX_N_GAP2_PERP : `FDX_N_GAP2};
      5'h0B: seg = '{FDX_K_FILL, `FDX_SYNC_BYTE, `FDX_N_SYNC};
      5'h0C: seg = '{FDX_K_MARK, `FDX_MARK_A1, `FDX_N_MARK};
      5'h0D: seg = '{FDX_K_BYTE, deleted ? `FDX_AM_DEL : `FDX_AM_DATA,
                     `FDX_N_ONE};
      5'h0E: seg = '{FDX_K_DATA, `FDX_SYNC_BYTE, data_bytes};
      5'h0F: seg = '{FDX_K_CRC, `FDX_SYNC_BYTE, `FDX_N_CRC};
      5'h10: seg = '{FDX_K_FILL, `FDX_GAP_BYTE, {8'h00, gap3_len}};
      default: seg = '{FDX_K_TAIL, `FDX_GAP_BYTE, `FDX_N_TAIL};
    endcase
  end
endmodule : fdx_layout

// file: rtl/fdx_pkg.sv
// Types shared by the disk command engine and its helpers.
package fdx_pkg;
  typedef enum logic [1:0] {
    FDX_CMD_WRDEL, FDX_CMD_VERIFY, FDX_CMD_FORMAT, FDX_CMD_NONE
  } fdx_cmd_t;
  typedef enum logic [1:0] {
    FDX_LAY_DD, FDX_LAY_ISO, FDX_LAY_PERP, FDX_LAY_RSVD
  } fdx_layout_t;
  typedef enum logic [2:0] {
    FDX_K_FILL, FDX_K_MARK, FDX_K_BYTE, FDX_K_ID, FDX_K_DATA, FDX_K_CRC,
    FDX_K_TAIL
  } fdx_kind_t;
  typedef struct packed {
    fdx_kind_t kind;
    logic [7:0] value;
    logic [15:0] count;
  } fdx_seg_t;
  typedef struct packed {
    logic [7:0] c;
    logic [7:0] h;
    logic [7:0] r;
    logic [7:0] n;
  } fdx_id_t;
  typedef struct packed {
    fdx_layout_t layout;
    logic two_side;
    logic implicit_stop;
    logic start;
    fdx_cmd_t cmd;
  } fdx_ctrl_t;
endpackage : fdx_pkg
